// ===== core/adc_readout_pkg.sv
// Package for the serial conversion readout block.
// Assumes one core clock; link pins are sampled, never used as clocks.
package adc_readout_pkg;
  localparam int unsigned RES_BITS    = 12;
  localparam int unsigned FRAME_EDGES = 16;
  localparam int unsigned LEAD_ZEROS  = 4;
  localparam int unsigned ACQ_CYCLES  = 3;
  localparam int unsigned CNT_W       = 4;
  localparam logic [11:0] CODE_POS_FS = 12'h7ff;
  localparam logic [11:0] CODE_NEG_FS = 12'h800;
  localparam logic [3:0]  CNT_LAST    = 4'hf;
  localparam logic [3:0]  CNT_FIRST_DATA = 4'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} conv_state_t;

  // Sampled analog difference handed to the converter core
  typedef struct packed {
    logic [11:0] code;
  } sample_t;

  // Serial pin group: value and enable of the tristated output
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } serial_pins_t;
endpackage

// ===== core/adc_serial_conversion_readout.sv
// Conversion sequencer and serial result readout of a 12-bit converter.
// Assumes frame select and serial clock come from a host, asynchronous to
// core_clk, with the serial clock much slower than core_clk.
// Operation
// RL1 - A conversion spans exactly sixteen serial clock cycles.
// RL2 - Host may end a frame early; the conversion is then dropped.
// RL3 - Result leaves on serial_out, most significant bit first.
// RL4 - Each bit belongs to the current conversion and leaves once resolved.
// RL5 - Open frame after a conversion starts the next one at once.
// RL6 - Host captures each bit on the serial clock rising edge.
// RL7 - First three clock cycles of a conversion are acquisition.
// RL8 - Input difference is sampled at conversion start and held.
// RL9 - Results are signed 12-bit codes, 7ffh high, 800h low.
// RL10 - serial_out is driven only while frame select is low.
// RL11 - Falling edges one to four give zeros, five to sixteen the result.
// RL12 - Early frame end aborts, floats output, restarts on next frame.
// RL13 - Sixteen-state falling edge count, restarted by frame select fall.
`timescale 1ns/10ps
module adc_serial_conversion_readout #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic        core_clk,         // 20 MHz core clock
  input  wire logic        sys_rst,          // Sync reset, high
  input  wire logic        frame_select_n,   // Frame select pin, low active
  input  wire logic        serial_clock,     // Serial clock pin
  input  wire logic [11:0] diff_code,        // Digitised pos minus neg input
  input  wire logic        diff_valid,       // Sample stream valid
  output logic             diff_ready,       // Sample stream ready
  output logic             serial_out,       // Serial data out value
  output logic             serial_out_oe,    // High while driving
  output logic             tracking,         // Input tracked (acquisition)
  output logic             conv_done,        // Pulse on full conversion
  output logic             conv_abort        // Pulse on aborted conversion
);
  // Two-flop synchronisers; first stage read only by second
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic       cs_n_q;
  logic       sck_q;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cs_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
      cs_n_q     <= 1'h1;
      sck_q      <= 1'h0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[0], frame_select_n};
      sck_sync_q <= {sck_sync_q[0], serial_clock};
      cs_n_q     <= cs_sync_q[1];
      sck_q      <= sck_sync_q[1];
    end
  end

  wire cs_n      = cs_sync_q[1];
  wire sck       = sck_sync_q[1];
  wire cs_fall   = cs_n_q && !cs_n;
  wire cs_rise   = !cs_n_q && cs_n;
  wire sck_fall  = sck_q && !sck && !cs_n;

  // Sample FIFO in the data path; drained one word per conversion
  logic [11:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  sample_fifo #(
    .WIDTH (adc_readout_pkg::RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_data   (diff_code),
    .in_valid  (diff_valid),
    .in_ready  (diff_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  adc_readout_pkg::conv_state_t state_q;
  adc_readout_pkg::conv_state_t state_d;
  logic [3:0]                   edge_cnt_q;
  adc_readout_pkg::sample_t     held_q;
  logic [11:0]                  shift_q;
  logic                         last_sample_q;
  adc_readout_pkg::serial_pins_t pins_q;

  // A frame select fall counts as the first falling edge when the
  // serial clock is already low; otherwise the next sck fall is first.
  wire start_low  = cs_fall && !sck;
  wire conv_edge  = sck_fall || start_low;
  wire wrap       = conv_edge &&
                    edge_cnt_q == adc_readout_pkg::CNT_LAST;         // [RL1]
  wire data_phase = edge_cnt_q >=
                    adc_readout_pkg::CNT_FIRST_DATA - 4'h1;          // [RL11]
  wire sample_pt  = conv_edge &&
                    edge_cnt_q == 4'(adc_readout_pkg::ACQ_CYCLES);   // [RL8]

  // Hold the oldest queued sample; repeat the last one if the stream runs dry
  assign fifo_pop = sample_pt && fifo_valid;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      adc_readout_pkg::ST_IDLE:
        if (cs_fall)
          state_d = adc_readout_pkg::ST_ACQ;
      adc_readout_pkg::ST_ACQ:
        if (cs_n)
          state_d = adc_readout_pkg::ST_IDLE;                        // [RL12]
        else if (sample_pt)
          state_d = adc_readout_pkg::ST_CONV;                        // [RL7]
      adc_readout_pkg::ST_CONV:
        if (cs_n)
          state_d = adc_readout_pkg::ST_IDLE;                        // [RL2]
        else if (wrap)
          state_d = adc_readout_pkg::ST_ACQ;                         // [RL5]
      default:
        state_d = adc_readout_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_q <= adc_readout_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // Edge counter: restart on frame start, wrap for the next conversion
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || cs_rise)
      edge_cnt_q <= '0;
    else if (cs_fall)
      edge_cnt_q <= start_low ? 4'h1 : 4'h0;                         // [RL13]
    else if (sck_fall)
      edge_cnt_q <= edge_cnt_q + 4'h1;                               // [RL13]
  end

  // Sample and hold; the held code is the signed result of this conversion
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      held_q        <= '0;
      last_sample_q <= 1'h0;
    end
    else if (sample_pt)
    begin
      held_q.code   <= fifo_valid ? fifo_data : held_q.code;   // [RL8] [RL9]
      last_sample_q <= fifo_valid;
    end
  end

  // Output shift: zeros on edges one to four, result msb first after
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pins_q  <= '0;
      shift_q <= '0;
    end
    else if (cs_n)
      pins_q  <= '0;                                                 // [RL10]
    else
    begin
      pins_q.dout_oe <= 1'h1;                                        // [RL10]
      if (sample_pt)
      begin
        // Fourth edge still emits a leading zero; latch the held word
        pins_q.dout <= 1'h0;                                         // [RL11]
        shift_q     <= fifo_valid ? fifo_data : held_q.code;
      end
      else if (conv_edge && data_phase &&
               state_q == adc_readout_pkg::ST_CONV)
      begin
        pins_q.dout <= shift_q[11];                                  // [RL3]
        shift_q     <= {shift_q[10:0], 1'h0};                        // [RL4]
      end
      else if (conv_edge)
        pins_q.dout <= 1'h0;                                         // [RL11]
    end
  end

  // Status pulses and acquisition flag
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tracking   <= 1'h0;
      conv_done  <= 1'h0;
      conv_abort <= 1'h0;
    end
    else
    begin
      tracking   <= state_d == adc_readout_pkg::ST_ACQ;              // [RL7]
      conv_done  <= wrap && state_q == adc_readout_pkg::ST_CONV;     // [RL1]
      // A frame closed right after a wrap has no edge of the new
      // conversion yet, so it is not counted as an abort
      conv_abort <= cs_rise && edge_cnt_q != 4'h0 &&
                    state_q != adc_readout_pkg::ST_IDLE;             // [RL12]
    end
  end

  // Host samples on rising sck; data settles well before it
  assign serial_out    = pins_q.dout;                                // [RL6]
  assign serial_out_oe = pins_q.dout_oe;
endmodule

// ===== core/sample_fifo.sv
// Parameterised FIFO holding digitised differential samples.
// Assumes the sampler pushes only when in_ready is high.
`timescale 1ns/10ps
module sample_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,       // Core clock
  input  wire logic             rst,       // Sync reset, high
  input  wire logic [WIDTH-1:0] in_data,   // Push data
  input  wire logic             in_valid,  // Push request
  output logic                  in_ready,  // Not full
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Pop request
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Count is one bit wider than the pointers so that full is reachable
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== tb/adc_host_model.sv
// Host model: frames conversions and shifts the results in.
// Assumes the link clock idles high and stands still between frames.
`timescale 1ns/10ps
module adc_host_model (
  output logic      frame_select_n, // Frame pin
  output logic      serial_clock,   // Link clock
  input  wire logic serial_out,     // Data bit
  input  wire logic serial_out_oe   // Drive enable
);
  logic [63:0] rx;
  // Released line reads high, the inverse of the cleared data bit
  wire         line = serial_out_oe ? serial_out : !serial_out;
  initial
  begin
    frame_select_n = 1'b1;
    serial_clock   = 1'b1;
    rx             = '0;
  end
  task automatic frame(input int unsigned n);
    frame_select_n = 1'b0;
    repeat (n)
    begin
      #200 serial_clock = 1'b0;
      #200 serial_clock = 1'b1;
      rx = {rx[62:0], line};
    end
    #100 frame_select_n = 1'b1;
    #300;
  endtask
endmodule

// ===== tb/adc_readout_monitor.sv
// Port checker for the conversion readout block.
// Assumes link pins change slowly against core_clk.
`timescale 1ns/10ps
module adc_readout_monitor (
  input wire logic core_clk,       // Clock
  input wire logic sys_rst,        // Reset
  input wire logic frame_select_n, // Frame pin
  input wire logic serial_clock,   // Link clock
  input wire logic diff_ready,     // FIFO room
  input wire logic serial_out,     // Data bit
  input wire logic serial_out_oe,  // Drive enable
  input wire logic tracking,       // Acquiring
  input wire logic conv_done,      // Done pulse
  input wire logic conv_abort      // Abort pulse
);
  logic       sc_q;
  logic [3:0] since_fall_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Saturating age of the last link clock fall
  always_ff @(posedge core_clk)
  begin
    sc_q         <= serial_clock;
    since_fall_q <= sys_rst ? 4'hf : (sc_q && !serial_clock) ? 4'h0 :
                    since_fall_q + {3'h0, since_fall_q != 4'hf};
  end
  sequence cs_high_s; frame_select_n [*5]; endsequence
  sequence cs_low_s; !frame_select_n [*5]; endsequence
  AST_OE_OFF: assert property (cs_high_s |-> !serial_out_oe)
    else $error("output driven outside frame");
  AST_OE_ON: assert property (cs_low_s |-> serial_out_oe)
    else $error("output not driven in frame");
  AST_TRACK_OFF: assert property (cs_high_s |-> !tracking)
    else $error("tracking outside frame");
  AST_TRACK_IN: assert property ($rose(tracking) |-> !frame_select_n)
    else $error("tracking began with frame closed");
  AST_DONE: assert property (conv_done |-> !frame_select_n ##1 !conv_done)
    else $error("done pulse malformed");
  AST_ABORT: assert property (conv_abort |-> frame_select_n && !conv_done)
    else $error("abort while frame open");
  AST_HOLD: assert property (!diff_ready && frame_select_n |=> !diff_ready)
    else $error("sample taken without conversion");
  AST_DOUT_SYNC: assert property ($changed(serial_out) && serial_out_oe
    && $past(serial_out_oe) |-> since_fall_q < 4'h7)
    else $error("data changed away from clock fall");
endmodule
bind adc_serial_conversion_readout adc_readout_monitor i_mon (.core_clk,
  .sys_rst, .frame_select_n, .serial_clock, .diff_ready, .serial_out,
  .serial_out_oe, .tracking, .conv_done, .conv_abort);

// ===== tb/tb.sv
// Self-checking bench of the readout block against a host model.
// Assumes a 20 MHz core clock and a 400 ns link clock from the host.
`timescale 1ns/10ps
`define CHECK(a, e) check_val(64'(a), 64'(e))
module tb;
  logic        core_clk, sys_rst, diff_valid;
  logic [11:0] diff_code;
  logic        diff_ready, serial_out, serial_out_oe, tracking;
  logic        conv_done, conv_abort;
  wire         frame_select_n, serial_clock;
  int          n_fail, compares, n_done, n_abort, d, a;
  logic [11:0] tbl [8] = '{12'h7ff, 12'h800, 12'h001, 12'h000,
                           12'hfff, 12'ha5a, 12'h5a5, 12'h123};
  adc_serial_conversion_readout #(.FIFO_DEPTH(8)) i_dut (.core_clk,
    .sys_rst, .frame_select_n, .serial_clock, .diff_code, .diff_valid,
    .diff_ready, .serial_out, .serial_out_oe, .tracking, .conv_done,
    .conv_abort);
  adc_host_model i_host (.frame_select_n, .serial_clock, .serial_out,
    .serial_out_oe);
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Pulses are counted mid-cycle, where they are settled
  always @(negedge core_clk)
  begin
    n_done  += conv_done;
    n_abort += conv_abort;
  end
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [11:0] c);
    logic ok;
    @(posedge core_clk);
    diff_code  <= c;
    diff_valid <= 1'b1;
    // Ready is taken before the edge that accepts the word
    do
    begin
      @(negedge core_clk);
      ok = diff_ready;
      @(posedge core_clk);
    end
    while (ok !== 1'b1);
    diff_valid <= 1'b0;
  endtask
  // Fixed offset keeps link edges clear of core_clk edges
  task automatic run(input int unsigned n);
    @(posedge core_clk);
    #13 i_host.frame(n);
  endtask
  task automatic t_fill_drain;
    foreach (tbl[i]) push(tbl[i]);
    @(negedge core_clk);
    `CHECK(diff_ready, 1'b0);
    foreach (tbl[i])
    begin
      d = n_done;
      a = n_abort;
      run(16);
      `CHECK(i_host.rx[15:0], {4'h0, tbl[i]});
      `CHECK(n_done - d, 1);
      `CHECK(n_abort - a, 0);
    end
    $display("test fill_drain done");
  endtask
  task automatic t_continuous;
    push(12'h9c3);
    push(12'h3c9);
    d = n_done;
    run(32);
    `CHECK(i_host.rx[31:0], {4'h0, 12'h9c3, 4'h0, 12'h3c9});
    `CHECK(n_done - d, 2);
    $display("test continuous done");
  endtask
  task automatic t_short;
    push(12'hc35);
    d = n_abort;
    run(9);
    `CHECK(i_host.rx[8:0], 9'b0000_11000);
    `CHECK(n_abort - d, 1);
    `CHECK(serial_out_oe, 1'b0);
    push(12'h0f0);
    run(16);
    `CHECK(i_host.rx[15:0], 16'h00f0);
    $display("test short_cycle done");
  endtask
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {n_fail, compares, n_done, n_abort} = '0;
    sys_rst    = 1'b1;
    diff_valid = 1'b0;
    diff_code  = 12'h000;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_fill_drain;
    t_continuous;
    t_short;
    finish_test;
  end
  initial
  begin
    #200000;
    n_fail++;
    finish_test;
  end
endmodule
